// ---- hw/pfp_top.sv ----
// parallel flash programming port: pin handshake, command layer, wishbone view
// How it works
// - erase-all opcode then data zero erases flash
// - any lock set aborts full erase entirely
// - set-lock mask bit n sets lock n
// - clear-lock mask bit n clears lock n
// - page-write-and-lock commands lock their region
// - get-lock read returns lock bit mask
// - set-gp mask bit n sets gp bit n
// - clear-gp pattern ones clear gp bits
// - get-gp read returns gp bit mask
// - set-security opcode then data zero sets security
// - security set disables the pin handshake completely
// - long erase pin hold with test select low erases, then clears security
// - memory write loads address, writes words, increments
// - get-version read returns the version word
// - fixed opcode values decode the commands
// - write handshake: latch, drop ready, execute, ready
// - read handshake: drive word, valid low, release
// - new command completes and flushes the previous
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "pfp_consts.svh"
module pfp_top
   import pfp_pkg::*;
#(
   parameter int unsigned ERASE_HOLD_CYC = `PFP_ERASE_HOLD_CYC,
   parameter logic [3:0] MODE_CMD = 4'h1,
   parameter logic [3:0] MODE_ADDR_LO = 4'h2,
   parameter logic [3:0] MODE_ADDR_HI = 4'h3,
   parameter logic [3:0] MODE_DATA = 4'h0,
   parameter logic [15:0] OP_ERASE_ALL = 16'h0001,
   parameter logic [15:0] OP_SET_LOCK = 16'h0002,
   parameter logic [15:0] OP_CLR_LOCK = 16'h0003,
   parameter logic [15:0] OP_PAGE_LOCK = 16'h0004,
   parameter logic [15:0] OP_ERASE_PAGE_LOCK = 16'h0005,
   parameter logic [15:0] VERSION = 16'h0001, // arbitrary value
   parameter int LOCK_SHIFT = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [3:0] mode_i,
   input wire logic [15:0] data_i,
   output logic [15:0] data_o,
   output logic data_oe_o,
   input wire logic command_strobe_n_i,
   input wire logic output_enable_n_i,
   output logic ready_o,
   output logic read_valid_n_o,
   input wire logic test_select_i,
   input wire logic erase_pin_i,
   output logic mem_wr_o,
   output logic [31:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   output logic flash_erase_o,
   input wire logic flash_erase_done_i,
   output logic page_flush_o
);
   // synchronised pin levels
   logic [3:0] mode_s; // mode selector
   logic [15:0] data_s; // data bus input
   logic strobe_n_s; // command strobe, low active
   logic oe_n_s; // output enable, low active
   logic test_s; // test select level
   logic erase_s; // erase pin level
   logic erase_fire; // erase pin held long enough

   // handshake and command state
   pfp_state_t state_reg, state_next; // sequencer
   pfp_cmd_t cmd_reg, cmd_next; // selected command
   logic [3:0] mode_reg, mode_next; // latched mode
   logic [15:0] arg_reg, arg_next; // latched data word
   logic [31:0] addr_reg, addr_next; // internal auto-increment address
   logic [15:0] lock_reg, lock_next; // lock bits
   logic [15:0] gp_reg, gp_next; // general purpose nonvolatile bits
   logic [15:0] pend_lock_reg, pend_lock_next; // regions to lock on flush
   logic sec_reg, sec_next; // security bit
   logic sec_clr_pend_reg, sec_clr_pend_next; // erase running for security clear
   logic abort_reg, abort_next; // sticky full erase abort flag
   logic [15:0] dout_reg, dout_next; // read word on the pins
   logic doe_reg, doe_next; // data bus drive enable
   logic valid_n_reg, valid_n_next; // read valid flag, low active
   logic mem_wr_reg, mem_wr_next; // memory write pulse
   logic [31:0] mem_addr_reg, mem_addr_next; // memory write address
   logic [15:0] mem_wdata_reg, mem_wdata_next; // memory write data
   logic erase_reg, erase_next; // flash erase request pulse
   logic flush_reg, flush_next; // load buffer flush pulse
   logic [15:0] read_word; // word a read handshake returns
   logic exec; // write handshake completes this cycle

   // wishbone state
   logic ack_reg, ack_next; // bus acknowledge
   logic [31:0] wb_dat_reg, wb_dat_next; // bus read data
   logic port_en_reg, port_en_next; // software enable of the pin port
   logic wb_hit; // active bus cycle
   logic wb_wr; // write taking effect this edge
   logic wb_clr_abort; // software clears the abort flag

   // pin synchronisers
   pfp_sync #(.W(20), .RST_VAL(20'h0_0000)) u_sync_bus (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({mode_i, data_i}),
      .q_o({mode_s, data_s})
   );
   pfp_sync #(.W(2), .RST_VAL(2'h3)) u_sync_strobe (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({command_strobe_n_i, output_enable_n_i}),
      .q_o({strobe_n_s, oe_n_s})
   );
   pfp_sync #(.W(2), .RST_VAL(2'h2)) u_sync_erase (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({test_select_i, erase_pin_i}),
      .q_o({test_s, erase_s})
   );

   // erase pin hold timer
   pfp_erase_timer #(.HOLD_CYC(ERASE_HOLD_CYC)) u_erase_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .erase_i(erase_s),
      .test_i(test_s),
      .fire_o(erase_fire)
   );

   assign exec = (state_reg == ST_WAIT) && oe_n_s && strobe_n_s;

   // read word chosen by the selected command
   always_comb begin
      case (cmd_reg)
         CMD_GET_LOCK: read_word = lock_reg;
         CMD_GET_GP: read_word = gp_reg;
         CMD_GET_VER: read_word = VERSION;
         default: read_word = 16'h0000;
      endcase
   end

   // handshake sequencer and command execution
   always_comb begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      mode_next = mode_reg;
      arg_next = arg_reg;
      addr_next = addr_reg;
      lock_next = lock_reg;
      gp_next = gp_reg;
      pend_lock_next = pend_lock_reg;
      sec_next = sec_reg;
      sec_clr_pend_next = sec_clr_pend_reg;
      abort_next = abort_reg & ~wb_clr_abort;
      dout_next = dout_reg;
      doe_next = doe_reg;
      valid_n_next = valid_n_reg;
      mem_wr_next = 1'b0;
      mem_addr_next = mem_addr_reg;
      mem_wdata_next = mem_wdata_reg;
      erase_next = 1'b0;
      flush_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // ready is shown here; a falling strobe latches mode and data
            if (sec_reg) begin
               state_next = ST_LOCKED;
            end else if (port_en_reg && !strobe_n_s) begin
               mode_next = mode_s;
               arg_next = data_s;
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!oe_n_s) begin
               // read handshake: drive the word and pull valid low
               dout_next = read_word;
               doe_next = 1'b1;
               valid_n_next = 1'b0;
               state_next = ST_DRIVE;
            end else if (strobe_n_s) begin
               // write handshake done: execute, then back to ready
               state_next = ST_IDLE;
               if (mode_reg == MODE_CMD) begin
                  // new command finishes the old one and flushes the buffer
                  flush_next = 1'b1;
                  lock_next = lock_reg | pend_lock_reg;
                  pend_lock_next = 16'h0000;
                  if (arg_reg == OP_ERASE_ALL) begin
                     cmd_next = CMD_ERASE_ALL;
                  end else if (arg_reg == OP_SET_LOCK) begin
                     cmd_next = CMD_SET_LOCK;
                  end else if (arg_reg == OP_CLR_LOCK) begin
                     cmd_next = CMD_CLR_LOCK;
                  end else if (arg_reg == OP_PAGE_LOCK || arg_reg == OP_ERASE_PAGE_LOCK) begin
                     cmd_next = CMD_PAGE_LOCK;
                  end else begin
                     case (arg_reg)
                        `PFP_OP_GET_LOCK: cmd_next = CMD_GET_LOCK;
                        `PFP_OP_SET_GP: cmd_next = CMD_SET_GP;
                        `PFP_OP_CLR_GP: cmd_next = CMD_CLR_GP;
                        `PFP_OP_GET_GP: cmd_next = CMD_GET_GP;
                        `PFP_OP_SET_SEC: cmd_next = CMD_SET_SEC;
                        `PFP_OP_MEM_WR: cmd_next = CMD_MEM_WR;
                        `PFP_OP_GET_VER: cmd_next = CMD_GET_VER;
                        default: cmd_next = CMD_NONE;
                     endcase
                  end
               end else if (mode_reg == MODE_ADDR_LO) begin
                  addr_next = {addr_reg[31:16], arg_reg};
               end else if (mode_reg == MODE_ADDR_HI) begin
                  addr_next = {arg_reg, addr_reg[15:0]};
               end else if (mode_reg == MODE_DATA) begin
                  case (cmd_reg)
                     CMD_ERASE_ALL: begin
                        if (arg_reg == `PFP_ARG_ZERO) begin
                           if (|lock_reg) begin
                              abort_next = 1'b1;
                           end else begin
                              erase_next = 1'b1;
                           end
                        end
                     end
                     CMD_SET_LOCK: lock_next = lock_reg | arg_reg;
                     CMD_CLR_LOCK: lock_next = lock_reg & ~arg_reg;
                     CMD_SET_GP: gp_next = gp_reg | arg_reg;
                     CMD_CLR_GP: gp_next = gp_reg & ~arg_reg;
                     CMD_SET_SEC: begin
                        if (arg_reg == `PFP_ARG_ZERO) begin
                           sec_next = 1'b1;
                           state_next = ST_LOCKED;
                        end
                     end
                     CMD_MEM_WR: begin
                        mem_wr_next = 1'b1;
                        mem_addr_next = addr_reg;
                        mem_wdata_next = arg_reg;
                        addr_next = addr_reg + 32'h0000_0001;
                     end
                     CMD_PAGE_LOCK: begin
                        // page data goes to the page buffer elsewhere; remember the region
                        pend_lock_next = pend_lock_reg | (16'h0001 << addr_reg[LOCK_SHIFT +: 4]);
                        addr_next = addr_reg + 32'h0000_0001;
                     end
                     default: begin
                        // no command or a read command selected: data is dropped
                        cmd_next = cmd_reg;
                     end
                  endcase
               end
            end
         end
         ST_DRIVE: begin
            // output enable back high: release the bus and raise valid
            if (oe_n_s) begin
               doe_next = 1'b0;
               valid_n_next = 1'b1;
               state_next = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            // read handshake ends when the strobe returns high
            if (strobe_n_s) begin
               state_next = ST_IDLE;
            end
         end
         ST_LOCKED: begin
            // port dead until the erase sequence has cleared security
            if (!sec_reg) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // erase pin sequence: erase flash first, then clear security
      if (erase_fire) begin
         sec_clr_pend_next = 1'b1;
         erase_next = 1'b1;
      end else if (sec_clr_pend_reg && flash_erase_done_i) begin
         sec_clr_pend_next = 1'b0;
         sec_next = 1'b0;
      end
   end

   // handshake and command registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         cmd_reg <= CMD_NONE;
         mode_reg <= 4'h0;
         arg_reg <= 16'h0000;
         addr_reg <= 32'h0000_0000;
         lock_reg <= 16'h0000;
         gp_reg <= 16'h0000;
         pend_lock_reg <= 16'h0000;
         sec_reg <= 1'b0;
         sec_clr_pend_reg <= 1'b0;
         abort_reg <= 1'b0;
         dout_reg <= 16'h0000;
         doe_reg <= 1'b0;
         valid_n_reg <= 1'b1;
         mem_wr_reg <= 1'b0;
         mem_addr_reg <= 32'h0000_0000;
         mem_wdata_reg <= 16'h0000;
         erase_reg <= 1'b0;
         flush_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         mode_reg <= mode_next;
         arg_reg <= arg_next;
         addr_reg <= addr_next;
         lock_reg <= lock_next;
         gp_reg <= gp_next;
         pend_lock_reg <= pend_lock_next;
         sec_reg <= sec_next;
         sec_clr_pend_reg <= sec_clr_pend_next;
         abort_reg <= abort_next;
         dout_reg <= dout_next;
         doe_reg <= doe_next;
         valid_n_reg <= valid_n_next;
         mem_wr_reg <= mem_wr_next;
         mem_addr_reg <= mem_addr_next;
         mem_wdata_reg <= mem_wdata_next;
         erase_reg <= erase_next;
         flush_reg <= flush_next;
      end
   end

   // wishbone decode; writes land on the edge where the master samples ack, one after the edge that raises it
   assign wb_hit = wb_cyc_i & wb_stb_i;
   assign wb_wr = wb_hit & ack_reg & wb_we_i & wb_sel_i[0];
   assign wb_clr_abort = wb_wr && (wb_adr_i == `PFP_WB_STATUS) &&
                         wb_dat_i[`PFP_STAT_ABORT_BIT];

   // wishbone slave: ack one cycle after the request, read data beside it
   always_comb begin
      ack_next = wb_hit & ~ack_reg;
      wb_dat_next = wb_dat_reg;
      port_en_next = port_en_reg;
      if (wb_hit && !ack_reg) begin
         case (wb_adr_i)
            `PFP_WB_CTRL: wb_dat_next = {31'h0000_0000, port_en_reg};
            `PFP_WB_LOCK: wb_dat_next = {16'h0000, lock_reg};
            `PFP_WB_GP: wb_dat_next = {16'h0000, gp_reg};
            `PFP_WB_STATUS: wb_dat_next = {16'h0000, 9'h000, state_reg, 1'b0,
                                           sec_clr_pend_reg, abort_reg, sec_reg};
            default: wb_dat_next = 32'h0000_0000;
         endcase
      end
      if (wb_wr && wb_adr_i == `PFP_WB_CTRL) begin
         port_en_next = wb_dat_i[`PFP_CTRL_EN_BIT];
      end
   end

   // wishbone registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         wb_dat_reg <= 32'h0000_0000;
         port_en_reg <= `PFP_CTRL_RST;
      end else begin
         ack_reg <= ack_next;
         wb_dat_reg <= wb_dat_next;
         port_en_reg <= port_en_next;
      end
   end

   // outputs
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = wb_dat_reg;
   assign ready_o = (state_reg == ST_IDLE) && port_en_reg && !sec_reg;
   assign data_o = dout_reg;
   assign data_oe_o = doe_reg;
   assign read_valid_n_o = valid_n_reg;
   assign mem_wr_o = mem_wr_reg;
   assign mem_addr_o = mem_addr_reg;
   assign mem_wdata_o = mem_wdata_reg;
   assign flash_erase_o = erase_reg;
   assign page_flush_o = flush_reg;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_read_start;
      state_reg == ST_WAIT && !oe_n_s;
   endsequence
   sequence s_read_end;
      state_reg == ST_DRIVE && oe_n_s;
   endsequence

   a_write_latch: assert property (ready_o && !strobe_n_s |=> !ready_o && arg_reg == $past(data_s))
      else $error("strobe did not latch data and drop ready");
   a_read_drive: assert property (s_read_start |=> data_oe_o && !read_valid_n_o && data_o == $past(read_word))
      else $error("read word not driven with valid low");
   a_read_release: assert property (s_read_end |=> !data_oe_o && read_valid_n_o ##0 !ready_o)
      else $error("bus not released after output enable rose");
   a_erase_abort: assert property (exec && mode_reg == MODE_DATA && cmd_reg == CMD_ERASE_ALL
      && arg_reg == 16'h0000 && (|lock_reg) && !erase_fire |=> !flash_erase_o && abort_reg)
      else $error("full erase ran while locked");
   a_erase_go: assert property (exec && mode_reg == MODE_DATA && cmd_reg == CMD_ERASE_ALL && lock_reg == 16'h0000 && arg_reg == 16'h0000 |=> flash_erase_o ##1 !flash_erase_o)
      else $error("full erase not requested once");
   a_set_lock: assert property (exec && mode_reg == MODE_DATA && cmd_reg == CMD_SET_LOCK |=> lock_reg == ($past(lock_reg) | $past(arg_reg)))
      else $error("set lock mask not applied");
   a_clr_lock: assert property (exec && mode_reg == MODE_DATA && cmd_reg == CMD_CLR_LOCK |=> (lock_reg & $past(arg_reg)) == 16'h0000)
      else $error("clear lock mask not applied");
   a_gp_update: assert property (exec && mode_reg == MODE_DATA && cmd_reg == CMD_CLR_GP |=> gp_reg == ($past(gp_reg) & ~$past(arg_reg)))
      else $error("clear gp pattern not applied");
   a_sec_lockout: assert property (sec_reg |-> !ready_o ##1 (!ready_o || !sec_reg))
      else $error("port ready while secured");
   a_mem_incr: assert property (exec && mode_reg == MODE_DATA && cmd_reg == CMD_MEM_WR |=> mem_wr_o && mem_addr_o == $past(addr_reg) && addr_reg == $past(addr_reg) + 32'h0000_0001)
      else $error("memory write or increment wrong");
   a_no_cmd: assert property (exec && mode_reg == MODE_DATA && cmd_reg == CMD_NONE |=> $stable(lock_reg) && $stable(gp_reg) && !mem_wr_o && !flash_erase_o)
      else $error("data changed state without a command");
   a_flush_new: assert property (exec && mode_reg == MODE_CMD |=> page_flush_o && pend_lock_reg == 16'h0000)
      else $error("new command did not flush");
   a_sec_erase: assert property (erase_fire |=> flash_erase_o && sec_clr_pend_reg)
      else $error("erase hold did not start the flash erase");
endmodule

// ---- hw/pfp_consts.svh ----
// constants for the parallel flash programming port command layer
`ifndef PFP_CONSTS_SVH
`define PFP_CONSTS_SVH

// pin bus widths
`define PFP_DATA_W 16
`define PFP_MODE_W 4
`define PFP_ADDR_W 32

// opcodes carried on the data bus in command select mode
`define PFP_OP_GET_LOCK 16'h0015
`define PFP_OP_SET_GP 16'h0034
`define PFP_OP_CLR_GP 16'h0044
`define PFP_OP_GET_GP 16'h0025
`define PFP_OP_SET_SEC 16'h0054
`define PFP_OP_MEM_WR 16'h001F
`define PFP_OP_GET_VER 16'h001E

// argument that erase-all and set-security demand
`define PFP_ARG_ZERO 16'h0000

// erase pin hold time and the clock rate it is counted at
`define PFP_ERASE_HOLD_MS 220
`define PFP_CLK_KHZ 125000
`define PFP_ERASE_HOLD_CYC (`PFP_ERASE_HOLD_MS * `PFP_CLK_KHZ)

// wishbone register byte offsets
`define PFP_WB_CTRL 8'h00
`define PFP_WB_LOCK 8'h04
`define PFP_WB_GP 8'h08
`define PFP_WB_STATUS 8'h0C

// field positions and reset values
`define PFP_CTRL_EN_BIT 0
`define PFP_CTRL_RST 1'b1
`define PFP_STAT_SEC_BIT 0
`define PFP_STAT_ABORT_BIT 1

`endif

// ---- hw/pfp_pkg.sv ----
// types shared by the parallel flash programming port
package pfp_pkg;

   // pin handshake sequencer states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_WAIT    = 3'b001,
      ST_DRIVE   = 3'b010,
      ST_RELEASE = 3'b011,
      ST_LOCKED  = 3'b100
   } pfp_state_t;

   // command currently selected by the programmer
   typedef enum logic [3:0] {
      CMD_NONE      = 4'b0000,
      CMD_ERASE_ALL = 4'b0001,
      CMD_SET_LOCK  = 4'b0010,
      CMD_CLR_LOCK  = 4'b0011,
      CMD_GET_LOCK  = 4'b0100,
      CMD_SET_GP    = 4'b0101,
      CMD_CLR_GP    = 4'b0110,
      CMD_GET_GP    = 4'b0111,
      CMD_SET_SEC   = 4'b1000,
      CMD_MEM_WR    = 4'b1001,
      CMD_GET_VER   = 4'b1010,
      CMD_PAGE_LOCK = 4'b1011
   } pfp_cmd_t;

endpackage

// ---- hw/pfp_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pfp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_reg; // first stage, read only by the second
   logic [W-1:0] s2_reg; // second stage
   logic [W-1:0] s3_reg; // third stage
   logic [W-1:0] q_reg; // filtered level
   logic [W-1:0] q_next;

   // a bit moves only when the second and third stages agree
   always_comb begin
      q_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (q_reg & (s2_reg ^ s3_reg));
   end

   // register chain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= q_next;
      end
   end

   assign q_o = q_reg;
endmodule

// ---- hw/pfp_erase_timer.sv ----
// erase pin hold timer for the security clear sequence
`timescale 1ns/1ps
`include "pfp_consts.svh"
module pfp_erase_timer #(
   parameter int unsigned HOLD_CYC = `PFP_ERASE_HOLD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic erase_i,
   input wire logic test_i,
   output logic fire_o
);
   logic [31:0] cnt_reg; // cycles the erase pin has stayed high
   logic [31:0] cnt_next;
   logic fire_reg; // one-cycle pulse once the hold count is reached
   logic fire_next;
   logic armed; // erase held with the test input low

   assign armed = erase_i & ~test_i;

   // count while held, saturate at the limit so it fires once per hold
   always_comb begin
      cnt_next = cnt_reg;
      fire_next = 1'b0;
      if (!armed) begin
         cnt_next = 32'h0000_0000;
      end else if (cnt_reg != HOLD_CYC[31:0]) begin
         cnt_next = cnt_reg + 32'h0000_0001;
         fire_next = (cnt_next == HOLD_CYC[31:0]);
      end
   end

   // registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 32'h0000_0000;
         fire_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         fire_reg <= fire_next;
      end
   end

   assign fire_o = fire_reg;
endmodule

// ---- sim/pfp_prog.sv ----
// programmer model that drives the pin handshakes of the port
`timescale 1ns/1ps
module pfp_prog (
   input wire logic clk_i,
   input wire logic ready_i,
   input wire logic read_valid_n_i,
   output logic [3:0] mode_o,
   output logic [15:0] data_o,
   output logic strobe_n_o,
   output logic oe_n_o
);
   // idle levels from time zero
   initial begin
      mode_o = 4'h0;
      data_o = 16'h0000;
      strobe_n_o = 1'b1;
      oe_n_o = 1'b1;
   end
   // bounded wait: 0 ready high, 1 ready low, 2 valid low, 3 valid high
   task automatic wt(input int w);
      int n;
      n = 0;
      while (!(w == 0 ? ready_i : w == 1 ? !ready_i : w == 2 ? !read_valid_n_i : read_valid_n_i)) begin
         @(posedge clk_i);
         n++;
         if (n > 300) pfp_top_test.finish_test(1);
      end
   endtask
   // one write handshake, with a read handshake inside when rd is set
   task automatic xfer(input logic [3:0] m, input logic [15:0] d, input bit rd, input bit nw);
      wt(0);
      mode_o <= m;
      data_o <= d;
      repeat (5) @(posedge clk_i);
      strobe_n_o <= 1'b0;
      wt(1);
      repeat (4) @(posedge clk_i);
      data_o <= ~d; // released bus shows the inverse, not the old value
      if (rd) begin
         oe_n_o <= 1'b0;
         wt(2);
         repeat (4) @(posedge clk_i);
         oe_n_o <= 1'b1;
         wt(3);
      end
      strobe_n_o <= 1'b1;
      if (!nw) begin
         @(posedge clk_i);
         wt(0);
      end
   endtask
endmodule

// ---- sim/pfp_top_test.sv ----
// self-checking bench for the parallel flash programming port
`timescale 1ns/1ps
`include "pfp_consts.svh"
module pfp_top_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, data_oe_o, ready_o, read_valid_n_o, mem_wr_o, flash_erase_o, sn, on, vq;
   logic page_flush_o;
   logic tp = 1'b1, ep = 1'b0, ed = 1'b0; // test select, erase pin, erase done
   logic [15:0] data_o, pd, m, g, c, w;
   logic [31:0] mem_addr_o, a;
   logic [15:0] mem_wdata_o;
   logic [3:0] mode_i;
   wire [15:0] data_i = data_oe_o ? data_o : pd;
   logic [15:0] rq[$];
   logic [47:0] mq[$];
   int failures = 0;
   int checks = 0;
   int erases = 0, flushes = 0;
   pfp_top #(.ERASE_HOLD_CYC(50)) uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i,
      .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_i, .data_i, .data_o,
      .data_oe_o, .command_strobe_n_i(sn), .output_enable_n_i(on), .ready_o, .read_valid_n_o,
      .test_select_i(tp), .erase_pin_i(ep), .mem_wr_o, .mem_addr_o, .mem_wdata_o,
      .flash_erase_o, .flash_erase_done_i(ed), .page_flush_o);
   pfp_prog p (.clk_i, .ready_i(ready_o), .read_valid_n_i(read_valid_n_o), .mode_o(mode_i),
      .data_o(pd), .strobe_n_o(sn), .oe_n_o(on));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task cmp(input string n, input logic [47:0] e, input logic [47:0] s);
      checks++;
      if (e !== s) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task finish_test(input bit hung);
      if (hung) failures++;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // classic wishbone read, held until ack is sampled
   task rg(input logic [7:0] ad, input logic [31:0] e, input string n);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_adr_i <= ad;
      do begin
         @(posedge clk_i);
         k++;
         if (k > 50) finish_test(1);
      end while (wb_ack_o !== 1'b1);
      cmp(n, 48'(e), 48'(wb_dat_o));
      wb_cyc_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task cmd(input logic [15:0] op, input logic [15:0] d);
      p.xfer(uut.MODE_CMD, op, 0, 0);
      p.xfer(uut.MODE_DATA, d, 0, 0);
   endtask
   task get(input logic [15:0] op, input logic [15:0] e, input string n);
      p.xfer(uut.MODE_CMD, op, 0, 0);
      rq.push_back(e);
      p.xfer(uut.MODE_DATA, 16'h0000, 1, 0);
      $display("test %s done", n);
   endtask
   // watcher: read words and memory writes against the oldest notes
   always @(posedge clk_i) begin
      vq <= read_valid_n_o;
      if (vq && !read_valid_n_o) cmp("read word", {1'b1, rq.pop_front()}, {data_oe_o, data_o});
      if (mem_wr_o) cmp("mem write", mq.pop_front(), {mem_addr_o, mem_wdata_o});
      if (flash_erase_o) erases++;
      if (page_flush_o) flushes++;
   end
   initial begin
      void'($urandom(52));
      m = 16'($urandom) | 16'h0001;
      g = 16'($urandom);
      c = 16'($urandom);
      a = $urandom;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rg(8'h00, 32'h0000_0001, "ctrl reset");
      rg(8'h10, 32'h0000_0000, "unmapped");
      p.xfer(uut.MODE_DATA, m, 0, 0);
      get(`PFP_OP_GET_LOCK, 16'h0000, "orphan data");
      cmd(uut.OP_SET_LOCK, m);
      get(`PFP_OP_GET_LOCK, m, "set lock");
      rg(8'h04, {16'h0000, m}, "lock reg");
      cmd(uut.OP_ERASE_ALL, 16'h0000);
      rg(8'h0C, 32'h0000_0002, "abort flag");
      cmp("erase on abort", 48'h0, 48'(erases));
      cmd(uut.OP_CLR_LOCK, m);
      get(`PFP_OP_GET_LOCK, 16'h0000, "clear lock");
      cmd(uut.OP_ERASE_ALL, 16'h0000);
      @(posedge clk_i);
      cmp("erase pulses", 48'h1, 48'(erases));
      cmd(`PFP_OP_SET_GP, g);
      cmd(`PFP_OP_CLR_GP, c);
      get(`PFP_OP_GET_GP, g & ~c, "gp bits");
      p.xfer(uut.MODE_CMD, `PFP_OP_MEM_WR, 0, 0);
      p.xfer(uut.MODE_ADDR_LO, a[15:0], 0, 0);
      p.xfer(uut.MODE_ADDR_HI, a[31:16], 0, 0);
      for (int i = 0; i < 3; i++) begin
         w = 16'($urandom);
         mq.push_back({a + 32'(i), w});
         p.xfer(uut.MODE_DATA, w, 0, 0);
      end
      get(`PFP_OP_GET_VER, uut.VERSION, "version");
      p.xfer(uut.MODE_CMD, `PFP_OP_SET_SEC, 0, 0);
      p.xfer(uut.MODE_DATA, 16'h0000, 0, 1);
      repeat (40) @(posedge clk_i);
      cmp("ready after security", 48'h0, 48'(ready_o));
      tp <= 1'b0;
      ep <= 1'b1;
      repeat (70) @(posedge clk_i);
      cmp("erase on hold", 48'h2, 48'(erases));
      ed <= 1'b1;
      @(posedge clk_i);
      ed <= 1'b0;
      p.wt(0);
      rg(8'h0C, 32'h0000_0002, "security cleared");
      cmp("notes left", 48'h0, 48'(rq.size() + mq.size()));
      cmp("flushes", 48'hd, 48'(flushes));
      finish_test(0);
   end
endmodule
